// >>> logic/gpio_data_pkg.sv
// ----------------------------------------------------------------------
// shared constants and carriers for the pin data slice, bits 10..4
// ----------------------------------------------------------------------
package gpio_data_pkg;

    // ------------------------------------------------------------------
    // slice geometry
    // ------------------------------------------------------------------
    localparam int PIN_LSB = 4;            // lowest register bit held
    localparam int PIN_W = 7;              // bits 10 down to 4
    localparam int BIT7_IDX = 3;           // register bit 7 in the slice
    localparam int ADDR_W = 8;             // register port address width
    localparam int DATA_W = 32;            // register port data width

    typedef logic [PIN_W-1:0] pin_vec_t;

    // ------------------------------------------------------------------
    // register offsets on the plain register port
    // ------------------------------------------------------------------
    localparam logic [ADDR_W-1:0] DATA_OFS = 8'h00;   // pin data
    localparam logic [ADDR_W-1:0] DIR_OFS = 8'h04;    // 1 = output
    localparam logic [ADDR_W-1:0] HP_SEL_OFS = 8'h08; // 1 = hot-plug use

    // ------------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------------
    localparam pin_vec_t DATA_RESET = 7'h00;
    localparam pin_vec_t DIR_RESET = 7'h00;
    localparam pin_vec_t HP_SEL_RESET = 7'h00;
    localparam logic STRAP_SYNC_RESET = 1'h1;  // read-only until sampled
    localparam logic FUNDAMENTAL_RESET_N_SYNC_RESET = 1'h0;   // held in clear until seen
    localparam pin_vec_t PIN_SYNC_RESET = 7'h00;
    localparam logic [DATA_W-1:0] RDATA_RESET = 32'h0000_0000;

    // ------------------------------------------------------------------
    // per-pin masks, slice index 0 is register bit 4
    // ------------------------------------------------------------------
    localparam pin_vec_t STRAP3_BITS = 7'h70;  // bits 10, 9, 8
    localparam pin_vec_t STRAP2_BITS = 7'h07;  // bits 6, 5, 4
    localparam pin_vec_t HP_IN_BITS = 7'h66;   // bits 10, 9, 6, 5
    localparam pin_vec_t HP_OUT_BITS = 7'h11;  // bits 8, 4

    // ------------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------------
    typedef struct packed {
        logic we;                  // one-cycle write strobe
        logic re;                  // one-cycle read strobe
        logic [ADDR_W-1:0] addr;   // byte address
        logic [DATA_W-1:0] wdata;  // write data
    } reg_req_s;

    typedef struct packed {
        logic load;                // one-cycle preload strobe
        pin_vec_t data;            // preload image for bits 10..4
    } eeprom_load_s;

endpackage : gpio_data_pkg

// >>> logic/gpio_data_bits.sv
`timescale 1ns/1ps
`default_nettype none

module gpio_data_bits
    import gpio_data_pkg::*;
(
    input wire logic clk,                      // 100 MHz
    input wire logic rst_n,                    // sync, active low
    input wire reg_req_s reg_req,              // register request
    output var logic [DATA_W-1:0] reg_rdata_q, // read data, next cycle
    input wire eeprom_load_s eeprom_load,      // preload from eeprom
    input wire logic fundamental_reset_n,      // pin, active low
    input wire logic third_downport_strap,     // pin strap
    input wire logic second_downport_strap,    // pin strap
    input wire pin_vec_t pin_in,               // pin levels
    output var pin_vec_t pin_out_q,            // pin drive level
    output var pin_vec_t pin_oe_q,             // pin drive enable
    input wire pin_vec_t hp_drive_level,       // from hot-plug logic
    output var pin_vec_t hp_sense_q            // to hot-plug logic
);

    // ------------------------------------------------------------------
    // decoding shared by several processes
    // ------------------------------------------------------------------

    // a strap high takes its bits away from software
    function automatic pin_vec_t valid_mask(input logic s3, input logic s2);
        pin_vec_t m;
        m = '1;
        if (s3) begin
            m = m & ~STRAP3_BITS;
        end
        if (s2) begin
            m = m & ~STRAP2_BITS;
        end
        return m;
    endfunction : valid_mask

    // ------------------------------------------------------------------
    // synchronisers for everything that arrives from pins
    // ------------------------------------------------------------------
    logic strap3_meta_q;
    logic strap3_sync_q;
    logic strap2_meta_q;
    logic strap2_sync_q;
    logic fundamental_reset_n_meta_q;
    logic fundamental_reset_n_sync_q;
    pin_vec_t pin_meta_q;
    pin_vec_t pin_sync_q;

    // straps reset high so only bit 7 is writable before they are seen
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            strap3_meta_q <= STRAP_SYNC_RESET;
            strap3_sync_q <= STRAP_SYNC_RESET;
            strap2_meta_q <= STRAP_SYNC_RESET;
            strap2_sync_q <= STRAP_SYNC_RESET;
        end else begin
            strap3_meta_q <= third_downport_strap;
            strap3_sync_q <= strap3_meta_q;
            strap2_meta_q <= second_downport_strap;
            strap2_sync_q <= strap2_meta_q;
        end
    end

    // fundamental reset is a pin too; it lags two cycles
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            fundamental_reset_n_meta_q <= FUNDAMENTAL_RESET_N_SYNC_RESET;
            fundamental_reset_n_sync_q <= FUNDAMENTAL_RESET_N_SYNC_RESET;
        end else begin
            fundamental_reset_n_meta_q <= fundamental_reset_n;
            fundamental_reset_n_sync_q <= fundamental_reset_n_meta_q;
        end
    end

    // pin levels, read back through the data register
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pin_meta_q <= PIN_SYNC_RESET;
            pin_sync_q <= PIN_SYNC_RESET;
        end else begin
            pin_meta_q <= pin_in;
            pin_sync_q <= pin_meta_q;
        end
    end

    // ------------------------------------------------------------------
    // register decode
    // ------------------------------------------------------------------
    pin_vec_t data_q;
    pin_vec_t dir_q;
    pin_vec_t hp_sel_q;
    pin_vec_t valid;
    pin_vec_t wr_mask;
    pin_vec_t drive_sw;
    pin_vec_t wbits;
    logic data_wr;
    logic dir_wr;
    logic hp_sel_wr;

    assign valid = valid_mask(strap3_sync_q, strap2_sync_q);
    assign wr_mask = valid & dir_q;
    assign drive_sw = valid & dir_q & ~hp_sel_q;
    assign wbits = reg_req.wdata[PIN_LSB +: PIN_W];
    assign data_wr = reg_req.we && (reg_req.addr == DATA_OFS);
    assign dir_wr = reg_req.we && (reg_req.addr == DIR_OFS);
    assign hp_sel_wr = reg_req.we && (reg_req.addr == HP_SEL_OFS);

    // ------------------------------------------------------------------
    // data bits
    // ------------------------------------------------------------------

    // clear beats preload beats software; a write in a preload cycle
    // is lost, which only matters if firmware races the eeprom
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            data_q <= DATA_RESET;
        end else if (!fundamental_reset_n_sync_q) begin
            data_q <= DATA_RESET;
        end else if (eeprom_load.load) begin
            // only valid bits take the image; bit 7 is always valid
            data_q <= (data_q & ~valid)
                      | (eeprom_load.data & valid);
        end else if (data_wr) begin
            data_q <= (data_q & ~wr_mask)
                      | (wbits & wr_mask);
        end
    end

    // ------------------------------------------------------------------
    // mode registers
    // ------------------------------------------------------------------

    // direction per pin, 1 means general-purpose output
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            dir_q <= DIR_RESET;
        end else if (dir_wr) begin
            dir_q <= wbits;
        end
    end

    // hot-plug selection per pin
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            hp_sel_q <= HP_SEL_RESET;
        end else if (hp_sel_wr) begin
            hp_sel_q <= wbits;
        end
    end

    // ------------------------------------------------------------------
    // pin drive, one slice per pin
    // ------------------------------------------------------------------
    for (genvar i = 0; i < PIN_W; i++) begin : g_pin
        // hot-plug outputs follow the hot-plug logic, hot-plug inputs
        // and invalid bits are left undriven
        always_ff @(posedge clk) begin
            if (!rst_n) begin
                pin_out_q[i] <= 1'h0;
                pin_oe_q[i] <= 1'h0;
            end else if (hp_sel_q[i] && HP_OUT_BITS[i]) begin
                pin_out_q[i] <= hp_drive_level[i];
                pin_oe_q[i] <= 1'h1;
            end else if (hp_sel_q[i]) begin
                pin_out_q[i] <= 1'h0;
                pin_oe_q[i] <= 1'h0;
            end else begin
                pin_out_q[i] <= data_q[i];
                pin_oe_q[i] <= drive_sw[i];
            end
        end
    end

    // sensed levels for the hot-plug logic, only where selected
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            hp_sense_q <= PIN_SYNC_RESET;
        end else begin
            hp_sense_q <= pin_sync_q & hp_sel_q & HP_IN_BITS;
        end
    end

    // ------------------------------------------------------------------
    // read port
    // ------------------------------------------------------------------

    // read data stand for one cycle only; unmapped reads give zero
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            reg_rdata_q <= RDATA_RESET;
        end else if (reg_req.re) begin
            reg_rdata_q <= RDATA_RESET;
            unique case (reg_req.addr)
                DATA_OFS: begin
                    // driven bits read the stored level, the rest the pin
                    reg_rdata_q[PIN_LSB +: PIN_W] <= (data_q & drive_sw)
                        | (pin_sync_q & ~drive_sw);
                end
                DIR_OFS: begin
                    reg_rdata_q[PIN_LSB +: PIN_W] <= dir_q;
                end
                HP_SEL_OFS: begin
                    reg_rdata_q[PIN_LSB +: PIN_W] <= hp_sel_q;
                end
                default: begin
                    reg_rdata_q <= RDATA_RESET;
                end
            endcase
        end else begin
            reg_rdata_q <= RDATA_RESET;
        end
    end

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    property p_input_write_ignored;
        @(posedge clk) disable iff (!rst_n)
        (data_wr && fundamental_reset_n_sync_q && !eeprom_load.load) |=>
            (((data_q ^ $past(data_q)) & ~$past(dir_q)) == '0);
    endproperty
    a_input_write_ignored: assert property (p_input_write_ignored)
        else $error("input-mode data bit changed on a write");

    property p_output_read;
        @(posedge clk) disable iff (!rst_n)
        (reg_req.re && reg_req.addr == DATA_OFS) |=>
            (((reg_rdata_q[PIN_LSB +: PIN_W] ^ $past(data_q))
              & $past(drive_sw)) == '0);
    endproperty
    a_output_read: assert property (p_output_read)
        else $error("output-mode read does not return driven level");

    property p_output_drive;
        @(posedge clk) disable iff (!rst_n)
        1'b1 |=>
            ((((pin_out_q ^ $past(data_q)) & $past(drive_sw)) == '0)
             && ((pin_oe_q & $past(drive_sw)) == $past(drive_sw)));
    endproperty
    a_output_drive: assert property (p_output_drive)
        else $error("output-mode pin not driven from data bit");

    property p_strap3_lock;
        @(posedge clk) disable iff (!rst_n)
        (data_wr && strap3_sync_q && fundamental_reset_n_sync_q && !eeprom_load.load) |=>
            (((data_q ^ $past(data_q)) & STRAP3_BITS) == '0);
    endproperty
    a_strap3_lock: assert property (p_strap3_lock)
        else $error("bits 10..8 written while third strap high");

    property p_strap2_lock;
        @(posedge clk) disable iff (!rst_n)
        (data_wr && strap2_sync_q && fundamental_reset_n_sync_q && !eeprom_load.load) |=>
            (((data_q ^ $past(data_q)) & STRAP2_BITS) == '0);
    endproperty
    a_strap2_lock: assert property (p_strap2_lock)
        else $error("bits 6..4 written while second strap high");

    property p_invalid_reads_pin;
        @(posedge clk) disable iff (!rst_n)
        (reg_req.re && reg_req.addr == DATA_OFS) |=>
            (((reg_rdata_q[PIN_LSB +: PIN_W] ^ $past(pin_sync_q))
              & ~$past(valid)) == '0);
    endproperty
    a_invalid_reads_pin: assert property (p_invalid_reads_pin)
        else $error("invalid bit does not read as pin level");

    property p_fundamental_reset_n_clear;
        @(posedge clk) disable iff (!rst_n)
        !fundamental_reset_n_sync_q |=> (data_q == DATA_RESET);
    endproperty
    a_fundamental_reset_n_clear: assert property (p_fundamental_reset_n_clear)
        else $error("data bits not cleared by fundamental reset");

    property p_eeprom_valid;
        @(posedge clk) disable iff (!rst_n)
        (eeprom_load.load && fundamental_reset_n_sync_q) |=>
            (((data_q ^ $past(eeprom_load.data)) & $past(valid)) == '0);
    endproperty
    a_eeprom_valid: assert property (p_eeprom_valid)
        else $error("valid bits not preloaded from eeprom image");

    property p_bit7_preload;
        @(posedge clk) disable iff (!rst_n)
        (eeprom_load.load && fundamental_reset_n_sync_q) |=>
            (data_q[BIT7_IDX] == $past(eeprom_load.data[BIT7_IDX]));
    endproperty
    a_bit7_preload: assert property (p_bit7_preload)
        else $error("bit 7 not preloaded from eeprom image");

    property p_hp_sense;
        @(posedge clk) disable iff (!rst_n)
        1'b1 |=>
            (hp_sense_q == ($past(pin_sync_q) & $past(hp_sel_q) & HP_IN_BITS));
    endproperty
    a_hp_sense: assert property (p_hp_sense)
        else $error("hot-plug input not passed to hot-plug logic");

    property p_hp_owns_pin;
        @(posedge clk) disable iff (!rst_n)
        1'b1 |=>
            ((((pin_out_q ^ $past(hp_drive_level)) & $past(hp_sel_q)
               & HP_OUT_BITS) == '0)
             && ((pin_oe_q & $past(hp_sel_q))
                 == ($past(hp_sel_q) & HP_OUT_BITS)));
    endproperty
    a_hp_owns_pin: assert property (p_hp_owns_pin)
        else $error("hot-plug pin not under hot-plug control");

endmodule : gpio_data_bits

`default_nettype wire

// >>> verification/board_pins.sv
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------------
// board circuitry on the seven general-purpose pins
// ----------------------------------------------------------------------
module board_pins
    import gpio_data_pkg::*;
(
    input wire pin_vec_t pin_out,      // device drive level
    input wire pin_vec_t pin_oe,       // device drive enable
    input wire pin_vec_t board_level,  // weak board drive level
    output var pin_vec_t pin_level     // resolved wire level
);
    // board drivers are weak, so the device wins wherever it drives
    always_comb begin
        pin_level = (pin_oe & pin_out) | (~pin_oe & board_level);
    end
endmodule : board_pins

`default_nettype wire

// >>> verification/gpio_data_bits_tb.sv
`timescale 1ns/1ps
`default_nettype none

module gpio_data_bits_ten_to_four_tb
    import gpio_data_pkg::*;
;
    // ------------------------------------------------------------------
    // stimulus and observed signals
    // ------------------------------------------------------------------
    localparam int LIMIT = 3000;  // whole run is about 110 cycles
    logic clk, rst_n, fundamental_reset_n_n, strap3, strap2;
    reg_req_s reg_req;
    eeprom_load_s ee;
    logic [DATA_W-1:0] rdata;
    pin_vec_t board, wire_lvl, pout, poe, hp_drv, hp_sense;
    int mismatches, compares, cycles;

    gpio_data_bits u_gpio_data_bits (
        .clk(clk), .rst_n(rst_n), .reg_req(reg_req), .reg_rdata_q(rdata),
        .eeprom_load(ee), .fundamental_reset_n(fundamental_reset_n_n),
        .third_downport_strap(strap3), .second_downport_strap(strap2),
        .pin_in(wire_lvl), .pin_out_q(pout), .pin_oe_q(poe),
        .hp_drive_level(hp_drv), .hp_sense_q(hp_sense)
    );

    board_pins u_board_pins (
        .pin_out(pout), .pin_oe(poe), .board_level(board),
        .pin_level(wire_lvl)
    );

    // ------------------------------------------------------------------
    // clock and hang guard
    // ------------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == LIMIT) begin
            mismatches++;
            complete_run();
        end
    end

    // ------------------------------------------------------------------
    // register port tasks and compares
    // ------------------------------------------------------------------
    task automatic settle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : settle

    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge clk);
        reg_req <= '{we: 1'b1, re: 1'b0, addr: a, wdata: d};
        @(posedge clk);
        reg_req <= '0;
    endtask : wr

    // read data stand only in the cycle after the strobe
    task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
        @(posedge clk);
        reg_req <= '{we: 1'b0, re: 1'b1, addr: a, wdata: '0};
        @(posedge clk);
        reg_req <= '0;
        #1;
        d = rdata;
    endtask : rd

    task automatic chk_word(input string what, input logic [DATA_W-1:0] exp,
                            input logic [DATA_W-1:0] got);
        compares++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : chk_word

    task automatic chk_pins(input string what, input pin_vec_t exp,
                            input pin_vec_t got);
        compares++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : chk_pins

    task automatic rd_chk(input string what, input logic [ADDR_W-1:0] a,
                          input logic [DATA_W-1:0] exp);
        logic [DATA_W-1:0] d;
        rd(a, d);
        chk_word(what, exp, d);
    endtask : rd_chk

    task automatic load(input pin_vec_t d);
        @(posedge clk);
        ee <= '{load: 1'b1, data: d};
        @(posedge clk);
        ee <= '0;
    endtask : load

    // a locked group keeps its stored bits and shows the pins instead
    task automatic strap_lock(input int which, input pin_vec_t mask);
        wr(DATA_OFS, 32'h0000_07f0);
        board <= 7'h00;
        if (which == 3) strap3 <= 1'b1;
        else strap2 <= 1'b1;
        settle(4);
        chk_pins("locked oe", ~mask, poe);
        wr(DATA_OFS, 32'h0000_0000);
        settle(3);
        rd_chk("locked read", DATA_OFS, 32'h0000_0000);
        strap3 <= 1'b0;
        strap2 <= 1'b0;
        settle(4);
        chk_pins("locked kept", mask, pout);
    endtask : strap_lock

    task automatic complete_run();
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : complete_run

    // ------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------
    initial begin
        rst_n = 1'b0;
        fundamental_reset_n_n = 1'b1;
        strap3 = 1'b0;
        strap2 = 1'b0;
        reg_req = '0;
        ee = '0;
        board = 7'h2a;
        hp_drv = 7'h00;
        mismatches = 0;
        compares = 0;
        cycles = 0;
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        settle(5);
        // reset values and an unmapped place
        rd_chk("dir reset", DIR_OFS, 32'h0000_0000);
        rd_chk("hp reset", HP_SEL_OFS, 32'h0000_0000);
        rd_chk("unmapped", 8'h0c, 32'h0000_0000);
        chk_pins("oe reset", 7'h00, poe);
        $display("test reset done");
        // input mode: reads follow the pins, writes are dropped
        rd_chk("input read", DATA_OFS, 32'h0000_02a0);
        wr(DATA_OFS, 32'hffff_ffff);
        board <= 7'h55;
        settle(4);
        rd_chk("input after wr", DATA_OFS, 32'h0000_0550);
        chk_pins("input oe", 7'h00, poe);
        wr(DIR_OFS, 32'h0000_07f0);
        settle(2);
        chk_pins("input wr lost", 7'h00, pout);
        $display("test input done");
        // output mode: the written bit drives the pin and reads back
        wr(DATA_OFS, 32'h0000_0550);
        settle(3);
        chk_pins("out level", 7'h55, pout);
        chk_pins("out oe", 7'h7f, poe);
        rd_chk("out read", DATA_OFS, 32'h0000_0550);
        $display("test output done");
        strap_lock(3, STRAP3_BITS);
        strap_lock(2, STRAP2_BITS);
        $display("test straps done");
        // preload, then fundamental reset clears
        load(7'h5a);
        settle(2);
        chk_pins("preload valid", 7'h5a, pout);
        fundamental_reset_n_n <= 1'b0;
        settle(5);
        chk_pins("fundamental_reset_n clear", 7'h00, pout);
        fundamental_reset_n_n <= 1'b1;
        strap3 <= 1'b1;
        strap2 <= 1'b1;
        settle(5);
        load(7'h7f);
        strap3 <= 1'b0;
        strap2 <= 1'b0;
        settle(4);
        chk_pins("preload bit7 only", 7'h08, pout);
        $display("test preload done");
        // hot-plug selection takes the pins away from the data bits
        board <= 7'h7f;
        hp_drv <= 7'h7f;
        wr(HP_SEL_OFS, 32'h0000_07f0);
        settle(5);
        chk_pins("hp oe", HP_OUT_BITS, poe);
        chk_pins("hp level", HP_OUT_BITS, pout);
        chk_pins("hp sense", HP_IN_BITS, hp_sense);
        hp_drv <= 7'h00;
        settle(5);
        chk_pins("hp low", 7'h00, pout);
        rd_chk("hp read", DATA_OFS, 32'h0000_06e0);
        $display("test hot-plug done");
        complete_run();
    end
endmodule : gpio_data_bits_ten_to_four_tb

`default_nettype wire
